// file: hw/pmt_regs.svh
// Register map, field positions and reset values of the period match timer
`ifndef PMT_REGS_SVH
`define PMT_REGS_SVH
`define PMT_ADDR_COUNT 4'h0
`define PMT_ADDR_PERIOD 4'h1
`define PMT_ADDR_CONTROL 4'h2
`define PMT_ADDR_FLAG 4'h3
`define PMT_ADDR_ENABLE 4'h4
`define PMT_CTL_DIV_LO 0
`define PMT_CTL_DIV_HI 1
`define PMT_CTL_RUN 2
`define PMT_CTL_POST_LO 3
`define PMT_CTL_POST_HI 6
`define PMT_FLAG_MATCH 1
`define PMT_COUNT_RST 8'h00
`define PMT_PERIOD_RST 8'hff
`define PMT_CONTROL_RST 7'h00
`define PMT_DIV4_LAST 4'h3
`define PMT_DIV16_LAST 4'hf
`define PMT_SUB_LAST 2'h3
`define PMT_CTL_MASK 8'h7f
`endif

// file: hw/pmt_pkg.sv
// Types shared by the period match timer files
package pmt_pkg;
  typedef enum logic [1:0] {
    PMT_DIV1,
    PMT_DIV4,
    PMT_DIV16
  } pmt_div_t;
  typedef logic [7:0] pmt_byte_t;
endpackage

// file: hw/pmt_postscale.sv
// Match event postscaler: counts matches and emits one pulse per ratio plus one matches
`include "pmt_regs.svh"
module pmt_postscale
  import pmt_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Control
  input wire logic clear,
  input wire logic [3:0] ratioSel,
  input wire logic matchIn,
  // Result
  output logic done
);
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  wire logic atLast = (cnt_q == ratioSel);

  assign done = matchIn && atLast && !clear;
  assign cnt_d = clear ? 4'h0 : (matchIn ? (atLast ? 4'h0 : cnt_q + 4'h1) : cnt_q);

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  post_bound_a: assert property (@(posedge mclk) disable iff (sys_rst)
    cnt_q <= ratioSel || $past(clear) || $changed(ratioSel))
    else $error("postscaler count passed its ratio");
endmodule

// file: hw/pmt_timer.sv
// Period match timer with Avalon-MM register slave and level interrupt
`include "pmt_regs.svh"
module pmt_timer
  import pmt_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Avalon-MM slave
  input wire logic [3:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWritedata,
  input wire logic [3:0] avsByteenable,
  output logic [31:0] avsReaddata,
  output logic avsWaitrequest,
  output logic [1:0] avsResponse,
  // Instruction clock tick (oscillator divided by four), same domain
  input wire logic instrTick,
  // Timer outputs
  output logic matchPulse,
  output logic compareTimebase,
  output logic serialShiftClk,
  output logic irq
);
  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [7:0] count_q;
  logic [7:0] count_d;
  logic [7:0] period_q;
  logic [7:0] period_d;
  logic [6:0] control_q;
  logic [6:0] control_d;
  logic [7:0] flag_q;
  logic [7:0] flag_d;
  logic [7:0] enable_q;
  logic [7:0] enable_d;
  logic [3:0] pre_q;
  logic [3:0] pre_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic ack_q;
  logic err_q;
  logic shiftClk_q;
  logic match_q;

  function automatic logic [3:0] preLast(input logic [1:0] sel);
    pmt_div_t d;
    d = sel[1] ? PMT_DIV16 : (sel[0] ? PMT_DIV4 : PMT_DIV1);
    case (d)
      PMT_DIV1: preLast = 4'h0;
      PMT_DIV4: preLast = `PMT_DIV4_LAST;
      PMT_DIV16: preLast = `PMT_DIV16_LAST;
      default: preLast = 4'h0;
    endcase
  endfunction

  function automatic logic [7:0] laneMerge(input logic [7:0] old, input logic [7:0] nw,
                                           input logic en);
    laneMerge = en ? nw : old;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  // One wait state: the access completes on the edge after the request is seen,
  // which keeps read data registered.
  wire logic busReq = (avsRead || avsWrite) && !ack_q;
  wire logic wrStb = avsWrite && ack_q;
  wire logic lane0 = avsByteenable[0];
  wire logic mapped = (avsAddress <= `PMT_ADDR_ENABLE);
  wire logic wrCount = wrStb && lane0 && (avsAddress == `PMT_ADDR_COUNT);
  wire logic wrPeriod = wrStb && lane0 && (avsAddress == `PMT_ADDR_PERIOD);
  wire logic wrControl = wrStb && lane0 && (avsAddress == `PMT_ADDR_CONTROL);
  wire logic wrFlag = wrStb && lane0 && (avsAddress == `PMT_ADDR_FLAG);
  wire logic wrEnable = wrStb && lane0 && (avsAddress == `PMT_ADDR_ENABLE);

  assign avsWaitrequest = (avsRead || avsWrite) && !ack_q;
  assign avsReaddata = rdata_q;
  assign avsResponse = err_q ? 2'b10 : 2'b00;

  ////////////////////////////////////////////////////////////////////////////
  // Counting path
  wire logic run = control_q[`PMT_CTL_RUN];
  wire logic [1:0] divSel = control_q[`PMT_CTL_DIV_HI:`PMT_CTL_DIV_LO];
  wire logic [3:0] postSel = control_q[`PMT_CTL_POST_HI:`PMT_CTL_POST_LO];
  wire logic scalerClear = wrCount || wrControl;
  wire logic preWrap = (pre_q >= preLast(divSel));
  wire logic tick = run && instrTick && preWrap && !scalerClear;
  wire logic match = (count_q == period_q);
  wire logic postDone;

  // Prescaler counts instruction ticks only while running
  assign pre_d = scalerClear ? 4'h0 :
                 ((run && instrTick) ? (preWrap ? 4'h0 : pre_q + 4'h1) : pre_q);

  // Software write wins over counting; a control write holds the count.
  // The tick that finds count equal to period reloads zero instead of stepping,
  // so one period spans period plus one ticks.
  assign count_d = wrCount ? laneMerge(count_q, avsWritedata[7:0], lane0) :
                   (tick && match) ? `PMT_COUNT_RST :
                   tick ? count_q + 8'h01 : count_q;
  assign period_d = wrPeriod ? avsWritedata[7:0] : period_q;
  assign control_d = wrControl ? avsWritedata[6:0] : control_q;
  assign enable_d = wrEnable ? (avsWritedata[7:0] & 8'h02) : enable_q;

  // Hardware set wins over a software clear in the same cycle
  wire logic [7:0] flagSet = {6'h00, postDone, 1'b0};
  wire logic [7:0] flagKeep = wrFlag ? (flag_q & avsWritedata[7:0]) : flag_q;
  assign flag_d = flagKeep | flagSet;

  assign rdata_d = (avsAddress == `PMT_ADDR_COUNT) ? {24'h0, count_q} :
                   (avsAddress == `PMT_ADDR_PERIOD) ? {24'h0, period_q} :
                   (avsAddress == `PMT_ADDR_CONTROL) ? {25'h0, control_q} :
                   (avsAddress == `PMT_ADDR_FLAG) ? {24'h0, flag_q} :
                   (avsAddress == `PMT_ADDR_ENABLE) ? {24'h0, enable_q} : 32'h0;

  pmt_postscale postscaler (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .clear(scalerClear),
    .ratioSel(postSel),
    .matchIn(match_q && run),
    .done(postDone)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Flip-flops
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      count_q <= `PMT_COUNT_RST;
      period_q <= `PMT_PERIOD_RST;
      control_q <= `PMT_CONTROL_RST;
      pre_q <= 4'h0;
    end else begin
      count_q <= count_d;
      period_q <= period_d;
      control_q <= control_d;
      pre_q <= pre_d;
    end
  end

  // Match registered into a one-cycle pulse in the cycle after the tick that finds equality
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      match_q <= 1'b0;
      flag_q <= 8'h00;
      enable_q <= 8'h00;
    end else begin
      match_q <= match && run && tick;
      flag_q <= flag_d;
      enable_q <= enable_d;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ack_q <= 1'b0;
      err_q <= 1'b0;
      rdata_q <= 32'h0;
    end else begin
      ack_q <= busReq;
      err_q <= busReq && !mapped;
      rdata_q <= busReq ? rdata_d : rdata_q;
    end
  end

  // Serial shift clock toggles on each match, halving the match rate
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      shiftClk_q <= 1'b0;
    end else if (match_q && run) begin
      shiftClk_q <= !shiftClk_q;
    end
  end

  assign matchPulse = match_q && run;
  assign compareTimebase = match_q && run;
  assign serialShiftClk = shiftClk_q;
  assign irq = |(flag_q & enable_q);

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  reload_zero_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (tick && match && !wrCount) |=> (count_q == 8'h00))
    else $error("count not reloaded after match");

  count_step_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (tick && !match && !wrCount) |=> (count_q == $past(count_q) + 8'h01))
    else $error("count did not step on tick");

  stopped_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (!run && !wrCount) |=> $stable(count_q))
    else $error("count moved while stopped");

  ctl_keeps_count_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (wrControl && !tick && !matchPulse) |=> $stable(count_q))
    else $error("control write changed count");

  scaler_clear_a: assert property (@(posedge mclk) disable iff (sys_rst)
    scalerClear |=> (pre_q == 4'h0))
    else $error("prescaler not cleared");

  flag_sticky_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (flag_q[`PMT_FLAG_MATCH] && !wrFlag) |=> flag_q[`PMT_FLAG_MATCH])
    else $error("match flag dropped without clear");

  flag_set_a: assert property (@(posedge mclk) disable iff (sys_rst)
    postDone |=> flag_q[`PMT_FLAG_MATCH])
    else $error("match flag not set");

  irq_gate_a: assert property (@(posedge mclk) disable iff (sys_rst)
    irq == (flag_q[`PMT_FLAG_MATCH] && enable_q[`PMT_FLAG_MATCH]))
    else $error("interrupt gating wrong");

  match_seen_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (tick && run && count_q == period_q) |=> matchPulse)
    else $error("match not raised");

  bus_answer_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (avsRead && avsWaitrequest) |=> !avsWaitrequest)
    else $error("bus answer late");
endmodule

// file: testbench/tb_top.sv
// Self-checking bench for the period match timer
`include "pmt_regs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] avsAddress = 4'h0;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic [31:0] avsWritedata = 32'h0;
  logic [31:0] avsReaddata;
  logic avsWaitrequest;
  logic [1:0] avsResponse;
  logic matchPulse;
  logic compareTimebase;
  logic serialShiftClk;
  logic irq;
  logic wrqS = 1'b1;
  logic lastS = 1'b0;
  logic irqPrev = 1'b0;
  logic [33:0] expQ[$];
  logic [33:0] expV;
  logic [31:0] rv;
  int failures = 0;
  int compares = 0;
  int cyc = 0;
  int pulses = 0;
  int lastAt = 0;
  int lastIv = 0;
  int toggles = 0;
  int atIrq = 0;
  int base;
  int divs[4] = '{1, 4, 16, 16};
  int posts[4] = '{0, 1, 7, 15};

  pmt_timer pmt_timer_inst (
    .mclk(mclk), .sys_rst(sys_rst), .avsAddress(avsAddress), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsWritedata(avsWritedata), .avsByteenable(4'hf),
    .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest), .avsResponse(avsResponse),
    .instrTick(1'b1), .matchPulse(matchPulse), .compareTimebase(compareTimebase),
    .serialShiftClk(serialShiftClk), .irq(irq)
  );

  initial begin
    forever #5 mclk = ~mclk;
  end

  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    if (failures == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Request is held until the edge that follows a low waitrequest in mid-cycle
  task automatic busOp(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    avsAddress <= a;
    avsWritedata <= d;
    avsWrite <= wr;
    avsRead <= !wr;
    do @(posedge mclk); while (wrqS !== 1'b0);
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [33:0] exp);
    expQ.push_back(exp);
    busOp(1'b0, a, 32'h0);
  endtask

  // Halfway through the cycle every output has settled, so no race with the edge
  always @(negedge mclk) begin
    wrqS = avsWaitrequest;
    cyc++;
    if (avsRead === 1'b1 && avsWaitrequest === 1'b0) begin
      expV = expQ.pop_front();
      check({avsResponse, avsReaddata}, expV);
    end
    check(34'(compareTimebase), 34'(matchPulse));
    if (matchPulse === 1'b1) begin
      pulses++;
      lastIv = cyc - lastAt;
      lastAt = cyc;
    end
    if (!sys_rst && serialShiftClk !== lastS) toggles++;
    lastS = serialShiftClk;
    if (irq === 1'b1 && irqPrev !== 1'b1) atIrq = pulses;
    irqPrev = irq;
  end

  initial begin
    #200000;
    failures++;
    conclude();
  end

  initial begin
    void'($urandom(57725));
    repeat (20) @(posedge mclk);
    sys_rst <= 1'b0;
    rd(`PMT_ADDR_COUNT, 34'h0);
    rd(`PMT_ADDR_PERIOD, 34'hff);
    rd(`PMT_ADDR_CONTROL, 34'h0);
    rd(`PMT_ADDR_FLAG, 34'h0);
    rd(4'h5, 34'h200000000);
    busOp(1'b1, 4'hf, 32'hff);
    rd(4'hf, 34'h200000000);
    for (int i = 0; i < 4; i++) begin
      rv = $urandom;
      busOp(1'b1, `PMT_ADDR_COUNT, rv);
      rd(`PMT_ADDR_COUNT, {26'h0, rv[7:0]});
      rv = $urandom;
      busOp(1'b1, `PMT_ADDR_PERIOD, rv);
      rd(`PMT_ADDR_PERIOD, {26'h0, rv[7:0]});
      busOp(1'b1, `PMT_ADDR_COUNT, 32'h5a);
      rv = $urandom & 32'h7b;
      busOp(1'b1, `PMT_ADDR_CONTROL, rv);
      rd(`PMT_ADDR_CONTROL, {26'h0, rv[7:0]});
      rd(`PMT_ADDR_COUNT, 34'h5a);
    end
    // Period of 6 counts keeps matches well apart from flag updates
    busOp(1'b1, `PMT_ADDR_PERIOD, 32'h5);
    for (int c = 0; c < 4; c++) begin
      busOp(1'b1, `PMT_ADDR_CONTROL, 32'h4 | c);
      base = pulses;
      wait (pulses >= base + 2);
      check(34'(lastIv), 34'(6 * divs[c]));
    end
    busOp(1'b1, `PMT_ADDR_ENABLE, 32'h2);
    foreach (posts[k]) begin
      busOp(1'b1, `PMT_ADDR_CONTROL, 32'h0);
      busOp(1'b1, `PMT_ADDR_FLAG, 32'h0);
      busOp(1'b1, `PMT_ADDR_COUNT, 32'h0);
      base = pulses;
      busOp(1'b1, `PMT_ADDR_CONTROL, (posts[k] << 3) | 32'h4);
      wait (irq === 1'b1);
      @(posedge mclk);
      check(34'(atIrq - base), 34'(posts[k] + 1));
      rd(`PMT_ADDR_FLAG, 34'h2);
    end
    base = pulses;
    wait (pulses >= base + 20);
    rd(`PMT_ADDR_FLAG, 34'h2);
    busOp(1'b1, `PMT_ADDR_CONTROL, 32'h0);
    busOp(1'b1, `PMT_ADDR_ENABLE, 32'h0);
    @(negedge mclk);
    check(34'(irq), 34'h0);
    busOp(1'b1, `PMT_ADDR_ENABLE, 32'h2);
    @(negedge mclk);
    check(34'(irq), 34'h1);
    busOp(1'b1, `PMT_ADDR_FLAG, 32'h0);
    @(negedge mclk);
    check(34'(irq), 34'h0);
    rd(`PMT_ADDR_FLAG, 34'h0);
    busOp(1'b1, `PMT_ADDR_COUNT, 32'h3);
    base = pulses;
    repeat (50) @(posedge mclk);
    check(34'(pulses), 34'(base));
    rd(`PMT_ADDR_COUNT, 34'h3);
    check(34'(toggles), 34'(pulses));
    conclude();
  end
endmodule
